// *** rtl/eecmd_engine.sv ***
// Command engine of a two-wire serial memory slave with a 64K x 8 array.
module eecmd_engine
  import eecmd_pkg::*;
#(
  parameter int unsigned WRITE_CYC = WRITE_CYCLES
)
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic write_protect,
  input  wire logic chip_select_pin_0,
  input  wire logic chip_select_pin_1,
  input  wire logic chip_select_pin_2,
  output logic      write_busy
);

  typedef struct packed {
    eecmd_state_e         state;
    logic [3:0]           bit_cnt;
    logic                 in_ack;
    logic                 mack;
    logic                 rd;
    logic [7:0]           shreg;
    logic [7:0]           tx;
    logic [ADDR_W-1:0]    ptr;
    logic                 wdata_any;
    logic [PAGE_SIZE-1:0] valid;
    logic [ADDR_W-PAGE_BITS-1:0] page;
    logic                 busy;
    logic [7:0]           prog_idx;
    logic [31:0]          wcnt;
    logic                 sda_oe;
  } eecmd_eng_s;

  eecmd_eng_s  st_r;
  eecmd_eng_s  st_nxt;
  eecmd_line_s ev;

  logic [7:0] mem_array [MEM_WORDS];
  logic [7:0] page_buf  [PAGE_SIZE];

  logic                 buf_we;
  logic [PAGE_BITS-1:0] buf_idx;
  logic                 mem_we;
  logic [ADDR_W-1:0]    mem_addr;

  eecmd_line_sampler u_sampler (
    .clk     (clk),
    .reset_n (reset_n),
    .pins    ({chip_select_pin_2, chip_select_pin_1, chip_select_pin_0,
               write_protect, sda_in, scl_in}),
    .ev      (ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decides whether a received control byte addresses this device while no write cycle is busy.
  function automatic logic ctrl_match(input logic [7:0] b, input logic [2:0] cs,
                                      input logic busy);
    ctrl_match = (b[7:4] == CTRL_CODE) && (b[3:1] == cs) && !busy;
  endfunction : ctrl_match

  always_comb
  begin
    st_nxt   = st_r;
    buf_we   = 1'b0;
    buf_idx  = st_r.ptr[PAGE_BITS-1:0];
    mem_we   = 1'b0;
    mem_addr = {st_r.page, st_r.prog_idx[PAGE_BITS-1:0]};

    if (st_r.busy)
    begin
      if (st_r.prog_idx != PROG_DONE)
      begin
        mem_we          = st_r.valid[st_r.prog_idx[PAGE_BITS-1:0]];
        st_nxt.prog_idx = st_r.prog_idx + 8'h01;
      end
      if (st_r.wcnt != CNT_ZERO)
      begin
        st_nxt.wcnt = st_r.wcnt - CNT_STEP;
      end
      else if (st_r.prog_idx == PROG_DONE)
      begin
        st_nxt.busy  = 1'b0;
        st_nxt.valid = '0;
      end
    end

    if (ev.start)
    begin
      st_nxt.state     = ST_CTRL;
      st_nxt.bit_cnt   = BIT_ZERO;
      st_nxt.in_ack    = 1'b0;
      st_nxt.sda_oe    = 1'b0;
      st_nxt.wdata_any = 1'b0;
    end
    else if (ev.stop)
    begin
      st_nxt.state  = ST_IDLE;
      st_nxt.in_ack = 1'b0;
      st_nxt.sda_oe = 1'b0;
      st_nxt.wdata_any = 1'b0;
      if (st_r.wdata_any && !st_r.busy)
      begin
        if (ev.wp)
        begin
          st_nxt.valid = '0;
        end
        else
        begin
          st_nxt.busy     = 1'b1;
          st_nxt.prog_idx = PROG_START;
          st_nxt.wcnt     = WRITE_CYC - 1;
        end
      end
    end
    else if (st_r.state == ST_RDATA)
    begin
      if (ev.scl_rise && st_r.in_ack)
      begin
        st_nxt.mack = ~ev.sda;
      end
      else if (ev.scl_fall && !st_r.in_ack && st_r.bit_cnt != BYTE_BITS)
      begin
        st_nxt.sda_oe  = ~st_r.tx[7];
        st_nxt.tx      = {st_r.tx[6:0], 1'b0};
        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
      end
      else if (ev.scl_fall && !st_r.in_ack)
      begin
        st_nxt.sda_oe = 1'b0;
        st_nxt.in_ack = 1'b1;
      end
      else if (ev.scl_fall)
      begin
        st_nxt.in_ack = 1'b0;
        if (st_r.mack)
        begin
          st_nxt.tx      = {mem_array[st_r.ptr][6:0], 1'b0};
          st_nxt.sda_oe  = ~mem_array[st_r.ptr][7];
          st_nxt.ptr     = st_r.ptr + PTR_STEP;
          st_nxt.bit_cnt = FIRST_TX_BITS;
        end
        else
        begin
          st_nxt.sda_oe = 1'b0;
          st_nxt.state  = ST_WAIT;
        end
      end
    end
    else if (st_r.state != ST_IDLE && st_r.state != ST_WAIT)
    begin
      if (ev.scl_rise && !st_r.in_ack && st_r.bit_cnt != BYTE_BITS)
      begin
        st_nxt.shreg   = {st_r.shreg[6:0], ev.sda};
        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
      end
      else if (ev.scl_fall && !st_r.in_ack && st_r.bit_cnt == BYTE_BITS)
      begin
        st_nxt.in_ack = 1'b1;
        st_nxt.sda_oe = 1'b1;
        unique case (st_r.state)
          ST_CTRL:
          begin
            if (!ctrl_match(st_r.shreg, ev.cs, st_r.busy))
            begin
              st_nxt.sda_oe = 1'b0;
              st_nxt.in_ack = 1'b0;
              st_nxt.state  = ST_WAIT;
            end
            else
            begin
              st_nxt.rd = st_r.shreg[0];
              if (!st_r.shreg[0])
              begin
                st_nxt.valid = '0;
              end
            end
          end
          ST_ADDR_HI: st_nxt.ptr[15:8] = st_r.shreg;
          ST_ADDR_LO: st_nxt.ptr[7:0] = st_r.shreg;
          ST_WDATA:
          begin
            buf_we = 1'b1;
            st_nxt.valid[st_r.ptr[PAGE_BITS-1:0]] = 1'b1;
            st_nxt.page = st_r.ptr[ADDR_W-1:PAGE_BITS];
            st_nxt.ptr[PAGE_BITS-1:0] = st_r.ptr[PAGE_BITS-1:0] + PAGE_STEP;
            st_nxt.wdata_any = 1'b1;
          end
          default: st_nxt.sda_oe = 1'b0;
        endcase
      end
      else if (ev.scl_fall && st_r.in_ack)
      begin
        st_nxt.in_ack  = 1'b0;
        st_nxt.sda_oe  = 1'b0;
        st_nxt.bit_cnt = BIT_ZERO;
        unique case (st_r.state)
          ST_CTRL:
          begin
            if (st_r.rd)
            begin
              st_nxt.state   = ST_RDATA;
              st_nxt.tx      = {mem_array[st_r.ptr][6:0], 1'b0};
              st_nxt.sda_oe  = ~mem_array[st_r.ptr][7];
              st_nxt.ptr     = st_r.ptr + PTR_STEP;
              st_nxt.bit_cnt = FIRST_TX_BITS;
            end
            else
            begin
              st_nxt.state = ST_ADDR_HI;
            end
          end
          ST_ADDR_HI: st_nxt.state = ST_ADDR_LO;
          ST_ADDR_LO: st_nxt.state = ST_WDATA;
          ST_WDATA:   st_nxt.state = ST_WDATA;
          default:    st_nxt.state = ST_WAIT;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '{state: ST_IDLE, bit_cnt: BIT_ZERO, in_ack: 1'b0, mack: 1'b0,
                rd: 1'b0, shreg: 8'h00, tx: 8'h00, ptr: PTR_RESET,
                wdata_any: 1'b0, valid: '0, page: '0, busy: 1'b0,
                prog_idx: PROG_DONE, wcnt: CNT_ZERO, sda_oe: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Array and page buffer have no reset, like the storage they model.
  always_ff @(posedge clk)
  begin
    if (buf_we)
    begin
      page_buf[buf_idx] <= st_r.shreg;
    end
    if (mem_we)
    begin
      mem_array[mem_addr] <= page_buf[st_r.prog_idx[PAGE_BITS-1:0]];
    end
  end

  // The line is open drain: it is only ever pulled low.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sda_out    <= 1'b0;
      sda_oe     <= 1'b0;
      write_busy <= 1'b0;
    end
    else
    begin
      sda_out    <= 1'b0;
      sda_oe     <= st_nxt.sda_oe;
      write_busy <= st_nxt.busy;
    end
  end

endmodule : eecmd_engine

// *** rtl/eecmd_pkg.sv ***
// Shared constants and types of the serial memory command engine.
package eecmd_pkg;

  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned PAGE_BITS     = 7;
  localparam int unsigned PAGE_SIZE     = 128;
  localparam int unsigned MEM_WORDS     = 65536;
  localparam logic [3:0]  CTRL_CODE     = 4'hA;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam logic [3:0]  BIT_ZERO      = 4'h0;
  localparam logic [3:0]  FIRST_TX_BITS = 4'h1;
  localparam logic [7:0]  PROG_START    = 8'h00;
  localparam logic [7:0]  PROG_DONE     = 8'h80;
  localparam logic [15:0] PTR_RESET     = 16'h0000;
  localparam logic [15:0] PTR_STEP      = 16'h0001;
  localparam logic [6:0]  PAGE_STEP     = 7'h01;
  localparam logic [31:0] CNT_ZERO      = 32'h00000000;
  localparam logic [31:0] CNT_STEP      = 32'h00000001;

  // Self-timed write duration in microseconds, and the clock rate.
  localparam int unsigned WRITE_TIME_US = 100;
  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;

  // Bit positions of the synchronised pin vector, and its width.
  localparam int unsigned PIN_SCL = 0;
  localparam int unsigned PIN_SDA = 1;
  localparam int unsigned PIN_WP  = 2;
  localparam int unsigned PIN_CS0 = 3;
  localparam int unsigned PIN_W   = 6;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WDATA,
    ST_RDATA,
    ST_WAIT
  } eecmd_state_e;

  // Bus events seen by the command engine, all on the system clock.
  typedef struct packed {
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;
    logic       sda;
    logic       wp;
    logic [2:0] cs;
  } eecmd_line_s;

endpackage : eecmd_pkg

// *** rtl/eecmd_line_sampler.sv ***
// Pin synchroniser and Start, Stop and clock edge detector.
module eecmd_line_sampler
  import eecmd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [PIN_W-1:0] pins,
  output eecmd_line_s      ev
);

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic             scl_d;
    logic             sda_d;
  } eecmd_smp_s;

  eecmd_smp_s st_r;
  eecmd_smp_s st_nxt;

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.s1    = pins;
    st_nxt.s2    = st_r.s1;
    st_nxt.scl_d = st_r.s2[PIN_SCL];
    st_nxt.sda_d = st_r.s2[PIN_SDA];
  end

  // Idle bus is high on both lines, so reset to that level.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '{s1: {PIN_W{1'b1}}, s2: {PIN_W{1'b1}}, scl_d: 1'b1, sda_d: 1'b1};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    ev.scl_rise = st_r.s2[PIN_SCL] & ~st_r.scl_d;
    ev.scl_fall = ~st_r.s2[PIN_SCL] & st_r.scl_d;
    ev.start    = st_r.s2[PIN_SCL] & st_r.scl_d & st_r.sda_d & ~st_r.s2[PIN_SDA];
    ev.stop     = st_r.s2[PIN_SCL] & st_r.scl_d & ~st_r.sda_d & st_r.s2[PIN_SDA];
    ev.sda      = st_r.s2[PIN_SDA];
    ev.wp       = st_r.s2[PIN_WP];
    ev.cs       = st_r.s2[PIN_CS0 +: 3];
  end

endmodule : eecmd_line_sampler

// *** verif/eecmd_engine_asserts.sv ***
// Port checks of the serial memory command engine.
module eecmd_engine_asserts
  import eecmd_pkg::*;
#(
  parameter int unsigned WRITE_CYC = WRITE_CYCLES
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic write_protect,
  input wire logic write_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] busy_cnt_r;

  // Length of the current busy period, cleared while idle.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      busy_cnt_r <= CNT_ZERO;
    else if (write_busy)
      busy_cnt_r <= busy_cnt_r + CNT_STEP;
    else
      busy_cnt_r <= CNT_ZERO;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_reset_quiet: assert property ($rose(reset_n) |-> !sda_oe && !write_busy)
    else $error("outputs active after reset");
  a_busy_no_ack: assert property (write_busy |-> !sda_oe)
    else $error("line pulled while busy");
  a_busy_min: assert property ($fell(write_busy) && $past(reset_n) |-> busy_cnt_r >= WRITE_CYC - 1)
    else $error("write cycle too short");
  a_busy_max: assert property (busy_cnt_r <= WRITE_CYC + 200)
    else $error("write cycle too long");
  a_busy_at_stop: assert property ($rose(write_busy) |-> scl_in && sda_in)
    else $error("write cycle not after stop");
  a_wp_gate: assert property ($rose(write_busy) |-> !$past(write_protect, 3))
    else $error("write cycle while protected");
  a_oe_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data driven while clock high");
  a_oe_steady: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data changed while clock high");
  a_ack_held: assert property ($rose(sda_oe) |-> sda_oe[*8])
    else $error("low bit not held");
endmodule : eecmd_engine_asserts

bind eecmd_engine eecmd_engine_asserts #(.WRITE_CYC(WRITE_CYC)) i_eecmd_engine_asserts (
  .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
  .write_protect(write_protect), .write_busy(write_busy));

// *** verif/eecmd_master.sv ***
// Behavioural two-wire bus master that drives the clock and the conditions.
module eecmd_master
  import eecmd_pkg::*;
(
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Quarter bit of two system clocks gives a 160 ns bus clock; the device answers
  // three clocks after a falling edge, so its bit still settles in the low phase.
  task automatic q(input int n);
    repeat (2 * n) @(posedge clk);
    #2;
  endtask : q

  task automatic start();
    scl = 1'b0;
    q(1);
    sda_low = 1'b0;
    q(1);
    scl = 1'b1;
    q(2);
    sda_low = 1'b1;
    q(1);
  endtask : start

  task automatic stop();
    scl = 1'b0;
    q(1);
    sda_low = 1'b1;
    q(1);
    scl = 1'b1;
    q(2);
    sda_low = 1'b0;
    q(2);
  endtask : stop

  task automatic bit_x(input logic v, output logic s);
    scl = 1'b0;
    q(1);
    sda_low = !v;
    q(1);
    scl = 1'b1;
    q(1);
    s = sda;
    q(1);
  endtask : bit_x

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask : wbyte

  task automatic rbyte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, s);
      b[i] = s;
    end
    bit_x(!mack, s);
  endtask : rbyte
endmodule : eecmd_master

// *** verif/eecmd_engine_bench.sv ***
// Self-checking bench of the command engine.
module eecmd_engine_bench
  import eecmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned WCYC = 600;
  logic       clk;
  logic       reset_n;
  logic       wp;
  logic [2:0] cs;
  logic       sda_oe;
  logic       sda_o;
  logic       busy;
  logic       m_scl;
  logic       m_low;
  logic       sda_w;
  logic       sb;
  logic [15:0] a;
  logic [7:0] mem [int];
  int         ptr;
  int         error_cnt;
  int         compares;

  assign sda_w = !(sda_oe | m_low);

  eecmd_engine #(.WRITE_CYC(WCYC)) i_eecmd_engine (
    .clk(clk), .reset_n(reset_n), .scl_in(m_scl), .sda_in(sda_w), .sda_out(sda_o),
    .sda_oe(sda_oe),
    .write_protect(wp), .chip_select_pin_0(cs[0]), .chip_select_pin_1(cs[1]),
    .chip_select_pin_2(cs[2]), .write_busy(busy));
  eecmd_master i_eecmd_master (.clk(clk), .sda(sda_w), .scl(m_scl), .sda_low(m_low));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  function automatic logic [7:0] ctl(input logic rd);
    return {CTRL_CODE, cs, rd};
  endfunction : ctl

  task automatic wr(input logic [15:0] wa, input int n);
    logic ack;
    logic [7:0] d;
    int tries;
    i_eecmd_master.start();
    i_eecmd_master.wbyte(ctl(1'b0), ack);
    chk("ack control", 1, ack);
    i_eecmd_master.wbyte(wa[15:8], ack);
    chk("ack high", 1, ack);
    i_eecmd_master.wbyte(wa[7:0], ack);
    chk("ack low", 1, ack);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      i_eecmd_master.wbyte(d, ack);
      chk("ack data", 1, ack);
      if (!wp)
        mem[{wa[15:7], 7'(wa[6:0] + i)}] = d;
    end
    ptr = {wa[15:7], 7'(wa[6:0] + n)};
    i_eecmd_master.stop();
    chk("busy", !wp, busy);
    tries = 0;
    ack = 1'b0;
    while (!ack && tries < 40)
    begin
      tries++;
      i_eecmd_master.start();
      i_eecmd_master.wbyte(ctl(1'b0), ack);
      i_eecmd_master.stop();
    end
    chk("first poll ack", wp, tries == 1);
    if (!ack)
    begin
      error_cnt++;
      print_verdict();
    end
  endtask : wr

  task automatic rd(input logic rnd, input logic [15:0] ra, input int n);
    logic ack;
    logic [7:0] d;
    if (rnd)
    begin
      i_eecmd_master.start();
      i_eecmd_master.wbyte(ctl(1'b0), ack);
      i_eecmd_master.wbyte(ra[15:8], ack);
      i_eecmd_master.wbyte(ra[7:0], ack);
      ptr = ra;
    end
    i_eecmd_master.start();
    i_eecmd_master.wbyte(ctl(1'b1), ack);
    chk("ack read", 1, ack);
    for (int i = 0; i < n; i++)
    begin
      i_eecmd_master.rbyte(i != n - 1, d);
      if (mem.exists(ptr))
        chk("read data", mem[ptr], d);
      ptr = (ptr + 1) % 65536;
    end
    chk("released", 0, sda_oe);
    chk("data out level", 0, sda_o);
    i_eecmd_master.stop();
  endtask : rd

  initial
  begin
    error_cnt = 0;
    compares = 0;
    ptr = 0;
    reset_n = 1'b0;
    wp = 1'b0;
    void'($urandom(32'hE58C));
    cs = 3'($urandom);
    repeat (6) @(posedge clk);
    #2;
    reset_n = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    chk("busy after reset", 0, busy);
    // short writes start low in a page so they never cross it.
    a = {9'($urandom), 7'h10};
    wr(a, 2);
    wr(a, 1);
    rd(1'b0, 16'h0000, 1);
    rd(1'b1, a, 1);
    rd(1'b0, 16'h0000, 1);
    wr({a[15:7], 7'h7E}, 130);
    rd(1'b1, {a[15:7], 7'h7C}, 4);
    rd(1'b1, {a[15:7], 7'h00}, 2);
    wp = 1'b1;
    wr(a, 1);
    wp = 1'b0;
    repeat (20) @(posedge clk);
    #2;
    chk("busy after toggle", 0, busy);
    rd(1'b1, a, 1);
    wr(16'hFFFF, 1);
    wr(16'h0000, 1);
    rd(1'b1, 16'hFFFF, 2);
    for (int k = 0; k < 2; k++)
    begin
      i_eecmd_master.start();
      i_eecmd_master.wbyte(k ? {CTRL_CODE, ~cs, 1'b0} : {4'h5, cs, 1'b0}, sb);
      chk("foreign ack", 0, sb);
      i_eecmd_master.stop();
    end
    i_eecmd_master.start();
    for (int k = 0; k < 4; k++)
      i_eecmd_master.bit_x(1'($urandom), sb);
    rd(1'b1, a, 1);
    print_verdict();
  end
endmodule : eecmd_engine_bench
